// ---- hdl/exciter_keying_channel_access.sv ----
// Purpose: keys an exciter, times channel access, busy abort and tests
// Assumes: busy pin and network notice are asynchronous inputs
// Notes:   page data itself is produced outside; this block gates it
`timescale 1ns/1ps
// Functional notes
// R1: wait channel change delay before access or keying
// R2: hold lead-in delay between keying and preamble
// R3: keep keyed for tail time after last bit
// R4: shared channel adds release margin before unkeying
// R5: busy with pages waiting starts busy timer
// R6: busy timer expiry aborts that channel's pages
// R7: busy timer holds while sending other channel
// R8: simulcast master sends busy abort notice on expiry
// R9: network busy abort notice aborts that channel
// R10: busy polarity follows inversion setting
// R11: warm-up precedes 512/1200 POCSAG preamble when enabled
// R12: codes 1-7 give square waves at rates
// R13: codes 8,9 step waves; stop ends output
// R14: forced ident after every network transmission
// R15: simulcast ident every n minutes, n divides 60
// R16: transmit only in selected shared frames
// R17: select lines become extra keylines when enabled
// R18: 10 ms tick drives all delay counters
module exciter_keying_channel_access
	import keying_pkg::*;
#(
	parameter int unsigned CHANNELS   = 4,
	parameter int unsigned TICK_CYC   = TICK_CYCLES,
	parameter int unsigned MINUTE_TK  = MINUTE_TICKS
) (
	input  wire logic                core_clk_i,
	input  wire logic                rstn_i,
	input  wire keying_cfg_t         cfg_i,
	input  wire logic [CHANNELS-1:0] pages_waiting_i,
	input  wire logic                send_req_i,
	input  wire logic [CH_W-1:0]     send_channel_i,
	input  wire logic                low_rate_pocsag_i,
	input  wire logic                last_bit_i,
	input  wire logic                page_data_i,
	input  wire logic                busy_pin_i,
	input  wire logic                net_abort_i,
	input  wire logic [CH_W-1:0]     net_abort_channel_i,
	input  wire logic [6:0]          frame_number_i,
	input  wire logic                frame_wr_i,
	input  wire logic [6:0]          frame_wr_addr_i,
	input  wire logic                frame_wr_sel_i,
	input  wire logic [3:0]          test_waveform_mode_i,
	input  wire logic                ident_done_i,
	output logic                     keyline_o,
	output logic [CH_W-1:0]          channel_select_o,
	output logic                     data_o,
	output logic                     send_grant_o,
	output logic                     preamble_enable_a_active_o,
	output logic                     ident_active_o,
	output logic [CHANNELS-1:0]      abort_o,
	output logic                     busy_abort_notice_o,
	output logic [CH_W-1:0]          busy_abort_channel_o,
	output logic                     channel_busy_o
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [1:0] busy_sync_reg;
	logic [1:0] nabt_sync_reg;
	logic       nabt_prev_reg;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_sync_reg <= 2'b11;
			nabt_sync_reg <= 2'b00;
			nabt_prev_reg <= 1'b0;
		end else begin
			busy_sync_reg <= {busy_sync_reg[0], busy_pin_i};
			nabt_sync_reg <= {nabt_sync_reg[0], net_abort_i};
			nabt_prev_reg <= nabt_sync_reg[1];
		end
	end

	logic busy_now;
	logic nabt_pulse;
	// low means busy unless inverted
	assign busy_now   = busy_sync_reg[1] ^ ~cfg_i.busy_polarity_invert; // [R10]
	assign nabt_pulse = nabt_sync_reg[1] & ~nabt_prev_reg;
	assign channel_busy_o = busy_now;

	// ------------------------------------------------------------
	// 10 ms tick
	// ------------------------------------------------------------
	logic [$clog2(TICK_CYC)-1:0] tick_cnt_reg;
	logic                        tick;

	assign tick = (tick_cnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_cnt_reg <= '0;
		end else if (tick) begin
			tick_cnt_reg <= '0; // [R18]
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// frame selection
	// ------------------------------------------------------------
	logic frame_ok;

	frame_select_mem #(
		.DEPTH (FRAME_COUNT),
		.AW    (7)
	) u_frames (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.wr_en_i    (frame_wr_i),
		.wr_addr_i  (frame_wr_addr_i),
		.wr_data_i  (frame_wr_sel_i),
		.rd_addr_i  (frame_number_i),
		.rd_data_o  (frame_ok)
	);

	// ------------------------------------------------------------
	// keying state machine
	// ------------------------------------------------------------
	key_state_t        state_reg;
	logic [7:0]        dly_reg;
	logic [CH_W-1:0]   chan_reg;
	logic              dly_done;
	logic              test_on;
	logic              sim_ident_reg;

	assign dly_done = (dly_reg == 8'h00);
	assign test_on  = (test_waveform_mode_i != TW_STOP);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			dly_reg   <= DELAY_RESET;
			chan_reg  <= '0;
		end else begin
			if (tick && !dly_done) begin
				dly_reg <= dly_reg - 1'b1; // [R18]
			end
			case (state_reg)
				ST_IDLE: begin
					if (send_req_i) begin
						chan_reg  <= send_channel_i;
						dly_reg   <= (send_channel_i != chan_reg) ?
							cfg_i.channel_change_delay : 8'h00; // [R1]
						state_reg <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					// [R1] access judged only after settling
					if (!send_req_i) begin
						state_reg <= ST_IDLE;
					end else if (dly_done && !busy_now &&
					             (!cfg_i.sync_simulcast_mode ||
					              frame_ok)) begin // [R16]
						dly_reg   <= cfg_i.keyup_lead_delay;
						state_reg <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (dly_done) begin
						if (cfg_i.preamble_enable_a && low_rate_pocsag_i) begin
							dly_reg   <= 8'(PREAMBLE_ENABLE_A_TICKS); // [R11]
							state_reg <= ST_WARM;
						end else begin
							state_reg <= ST_SEND; // [R2]
						end
					end
				end
				ST_WARM: begin
					if (dly_done) begin
						state_reg <= ST_SEND; // [R11]
					end
				end
				ST_SEND: begin
					if (last_bit_i) begin
						dly_reg   <= cfg_i.keyup_tail_delay; // [R3]
						state_reg <= ST_TAIL;
					end
				end
				ST_TAIL: begin
					if (dly_done) begin
						if (cfg_i.channel_shared) begin
							dly_reg   <= cfg_i.share_release_margin; // [R4]
							state_reg <= ST_MARGIN;
						end else if (cfg_i.station_ident && cfg_i.net_mode) begin
							state_reg <= ST_IDENT; // [R14]
						end else begin
							state_reg <= ST_IDLE; // [R3]
						end
					end
				end
				ST_MARGIN: begin
					if (dly_done) begin
						state_reg <= (cfg_i.station_ident && cfg_i.net_mode) ?
							ST_IDENT : ST_IDLE; // [R4]
					end
				end
				ST_IDENT: begin
					if (ident_done_i) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	logic keyed;
	assign keyed = (state_reg == ST_LEAD) || (state_reg == ST_WARM) ||
	               (state_reg == ST_SEND) || (state_reg == ST_TAIL) ||
	               (state_reg == ST_MARGIN) || (state_reg == ST_IDENT) ||
	               test_on || sim_ident_reg;
	assign send_grant_o    = (state_reg == ST_SEND);
	assign preamble_enable_a_active_o = (state_reg == ST_WARM);

	// ------------------------------------------------------------
	// simulcast periodic ident
	// ------------------------------------------------------------
	logic [12:0] min_cnt_reg;
	logic [5:0]  min_reg;
	logic        n_divides;

	always_comb begin
		case (cfg_i.ident_minutes)
			6'd1, 6'd2, 6'd3, 6'd4, 6'd5, 6'd6, 6'd10, 6'd12,
			6'd15, 6'd20, 6'd30: n_divides = 1'b1;
			default: n_divides = (cfg_i.ident_minutes == 6'd60); // [R15]
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			min_cnt_reg   <= '0;
			min_reg       <= '0;
			sim_ident_reg <= 1'b0;
		end else begin
			if (sim_ident_reg && ident_done_i) begin
				sim_ident_reg <= 1'b0;
			end
			if (tick) begin
				if (min_cnt_reg == 13'(MINUTE_TK - 1)) begin
					min_cnt_reg <= '0;
					if (min_reg + 6'd1 >= cfg_i.ident_minutes) begin
						min_reg <= '0;
						if (cfg_i.sync_simulcast_mode && n_divides) begin
							sim_ident_reg <= 1'b1; // [R15]
						end
					end else begin
						min_reg <= min_reg + 6'd1;
					end
				end else begin
					min_cnt_reg <= min_cnt_reg + 13'd1;
				end
			end
		end
	end

	assign ident_active_o = (state_reg == ST_IDENT) || sim_ident_reg;

	// ------------------------------------------------------------
	// busy timers, one per channel
	// ------------------------------------------------------------
	logic [CHANNELS-1:0] expire;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_busy
			logic [7:0] bt_reg;
			logic       run_reg;
			logic       this_ch;
			logic       other_tx;

			assign this_ch  = (chan_reg == CH_W'(g));
			assign other_tx = keyed && !this_ch;
			assign expire[g] = run_reg && (bt_reg == 8'h00) && !other_tx;

			always_ff @(posedge core_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					bt_reg  <= 8'h00;
					run_reg <= 1'b0;
				end else if (!pages_waiting_i[g] || expire[g]) begin
					run_reg <= 1'b0;
				end else if (!run_reg) begin
					if (this_ch && busy_now && state_reg == ST_SETTLE &&
					    dly_done) begin
						run_reg <= 1'b1; // [R5]
						bt_reg  <= cfg_i.busy_abort_limit;
					end
				end else if (this_ch && !busy_now) begin
					run_reg <= 1'b0;
				end else if (tick && !other_tx) begin
					bt_reg <= bt_reg - 1'b1; // [R7] held on other channel
				end
			end

			always_ff @(posedge core_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					abort_o[g] <= 1'b0;
				end else begin
					abort_o[g] <= expire[g] || (nabt_pulse &&
						(cfg_i.master_mode || cfg_i.net_mode) &&
						net_abort_channel_i == CH_W'(g)); // [R6] [R9]
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// busy abort notice
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_abort_notice_o  <= 1'b0;
			busy_abort_channel_o <= '0;
		end else begin
			busy_abort_notice_o <= cfg_i.master_mode && (|expire); // [R8]
			for (int i = 0; i < CHANNELS; i++) begin
				if (expire[i]) begin
					busy_abort_channel_o <= CH_W'(i);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// test waveforms
	// ------------------------------------------------------------
	logic [16:0] hb_len;
	logic [16:0] hb_cnt_reg;
	logic [1:0]  step_reg;
	logic        sq_reg;
	logic        is_step;

	always_comb begin
		is_step = 1'b0;
		case (test_waveform_mode_i)
			4'h1: hb_len = 17'(HB_512); // [R12]
			4'h2: hb_len = 17'(HB_1200);
			4'h3: hb_len = 17'(HB_2400);
			4'h4: hb_len = 17'(HB_300);
			4'h5: hb_len = 17'(HB_600);
			4'h6: hb_len = 17'(HB_1600);
			4'h7: hb_len = 17'(HB_3200);
			4'h8: begin
				hb_len  = 17'(HB_1600 * 2); // [R13]
				is_step = 1'b1;
			end
			4'h9: begin
				hb_len  = 17'(HB_3200 * 2);
				is_step = 1'b1;
			end
			default: hb_len = 17'h00001;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hb_cnt_reg <= '0;
			sq_reg     <= 1'b0;
			step_reg   <= 2'b00;
		end else if (!test_on) begin
			hb_cnt_reg <= '0; // [R13] stop ends output
			sq_reg     <= 1'b0;
			step_reg   <= 2'b00;
		end else if (hb_cnt_reg >= hb_len - 17'h00001) begin
			hb_cnt_reg <= '0;
			sq_reg     <= ~sq_reg;
			step_reg   <= step_reg + 2'b01;
		end else begin
			hb_cnt_reg <= hb_cnt_reg + 17'h00001;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_o    <= 1'b0;
			keyline_o <= 1'b0;
		end else begin
			keyline_o <= keyed; // [R2] [R3]
			if (test_on) begin
				// step wave approximated by a two-bit staircase msb
				data_o <= is_step ? step_reg[1] : sq_reg; // [R12] [R13]
			end else begin
				data_o <= (state_reg == ST_SEND) ? page_data_i : 1'b0; // [R2]
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			channel_select_o <= '0;
		end else if (cfg_i.select_as_keyline) begin
			channel_select_o <= {CH_W{keyed}}; // [R17]
		end else begin
			channel_select_o <= chan_reg;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_lead_no_data;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == ST_LEAD && !test_on) |=> !data_o;
	endproperty
	a_lead_no_data: assert property (p_lead_no_data) // [R2]
		else $error("data during lead-in");

	property p_polarity;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!cfg_i.busy_polarity_invert |-> (busy_now == !busy_sync_reg[1]);
	endproperty
	a_polarity: assert property (p_polarity) // [R10]
		else $error("busy polarity wrong");

	property p_tail_keyed;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == ST_TAIL) |=> keyline_o;
	endproperty
	a_tail_keyed: assert property (p_tail_keyed) // [R3]
		else $error("unkeyed in tail");

	property p_settle_wait;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == ST_SETTLE && !dly_done) |=> state_reg != ST_LEAD;
	endproperty
	a_settle_wait: assert property (p_settle_wait) // [R1]
		else $error("keyed before settle");

	property p_notice;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cfg_i.master_mode && |expire) |=> busy_abort_notice_o;
	endproperty
	a_notice: assert property (p_notice) // [R8]
		else $error("missing busy abort notice");

	property p_abort;
		@(posedge core_clk_i) disable iff (!rstn_i)
		expire[0] |=> abort_o[0];
	endproperty
	a_abort: assert property (p_abort) // [R6]
		else $error("expiry without abort");

	property p_tick;
		@(posedge core_clk_i) disable iff (!rstn_i)
		tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick) // [R18]
		else $error("tick too long");

	property p_stop;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!test_on && state_reg == ST_IDLE) |=> !data_o;
	endproperty
	a_stop: assert property (p_stop) // [R13]
		else $error("waveform after stop");
endmodule : exciter_keying_channel_access

// ---- hdl/frame_select_mem.sv ----
// Purpose: per-frame time share selection store
// Assumes: one write port, registered read
// Notes:   all frames start deselected
`timescale 1ns/1ps
module frame_select_mem #(
	parameter int unsigned DEPTH = 128,
	parameter int unsigned AW    = 7
) (
	input  wire logic          core_clk_i,
	input  wire logic          rstn_i,
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic          wr_data_i,
	input  wire logic [AW-1:0] rd_addr_i,
	output logic               rd_data_o
);
	logic [DEPTH-1:0] sel_reg;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_reg <= '0;
		end else if (wr_en_i) begin
			sel_reg[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= 1'b0;
		end else begin
			rd_data_o <= sel_reg[rd_addr_i];
		end
	end
endmodule : frame_select_mem

// ---- hdl/keying_pkg.sv ----
// Purpose: shared constants and carriers for exciter keying and access
// Assumes: 50 MHz core clock, 10 ms delay tick
// Notes:   all delay settings are counts of 10 ms ticks
package keying_pkg;
	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned TICK_MS         = 10;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned CH_W            = 2;
	localparam int unsigned FRAME_COUNT     = 128;
	localparam int unsigned PREAMBLE_ENABLE_A_TICKS    = 10;
	localparam int unsigned IDENT_TICKS     = 100;
	localparam int unsigned MINUTE_TICKS    = 6000;
	localparam logic [7:0]  DELAY_RESET     = 8'h00;
	// half-bit periods in cycles for each test waveform
	localparam int unsigned HB_512   = CLK_HZ / (2 * 512);
	localparam int unsigned HB_1200  = CLK_HZ / (2 * 1200);
	localparam int unsigned HB_2400  = CLK_HZ / (2 * 2400);
	localparam int unsigned HB_300   = CLK_HZ / (2 * 300);
	localparam int unsigned HB_600   = CLK_HZ / (2 * 600);
	localparam int unsigned HB_1600  = CLK_HZ / (2 * 1600);
	localparam int unsigned HB_3200  = CLK_HZ / (2 * 3200);
	localparam logic [3:0]  TW_STOP  = 4'h0;

	typedef struct packed {
		logic [7:0] channel_change_delay;
		logic [7:0] keyup_lead_delay;
		logic [7:0] keyup_tail_delay;
		logic [7:0] share_release_margin;
		logic [7:0] busy_abort_limit;
		logic       busy_polarity_invert;
		logic       preamble_enable_a;
		logic       select_as_keyline;
		logic       channel_shared;
		logic       station_ident;
		logic       sync_simulcast_mode;
		logic       master_mode;
		logic       net_mode;
		logic [5:0] ident_minutes;
	} keying_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETTLE = 3'b001,
		ST_LEAD  = 3'b010,
		ST_WARM  = 3'b011,
		ST_SEND  = 3'b100,
		ST_TAIL  = 3'b101,
		ST_MARGIN = 3'b110,
		ST_IDENT = 3'b111
	} key_state_t;
endpackage : keying_pkg

// ---- tb/exciter_keying_channel_access_tb.sv ----
// Purpose: self-checking bench for exciter keying and access
// Assumes: tick shortened to 10 cycles, stimulus on falling edge
// Notes:   tick alignment gives delay checks one tick of slack each side
`timescale 1ns/1ps
module exciter_keying_channel_access_tb;
	import keying_pkg::*;
	localparam int T = 10;
	keying_cfg_t     cfg;
	logic            core_clk_i, rstn_i, req, lastb, pdata, pin, nab;
	logic            fwr, fsel, lowr, idone, carrier, v, wseen;
	logic [3:0]      waiting, abort_o, tmode;
	logic [CH_W-1:0] sch, nch, csel, bch, prev;
	logic [6:0]      fnum, faddr;
	logic            key, dat, grant, warm, idact, notice, cbusy;
	logic [2:0]      nseen;
	logic [7:0]      keyups;
	int              num_errors, checks_done, cyc, n;
	logic [2:0]      brow [4] = '{3'h0, 3'h3, 3'h4, 3'h7};
	int              xr [3][6] = '{'{1, 2, 2, 0, 0, 0},
		'{1, 1, 1, 1, 0, 1}, '{2, 1, 2, 0, 1, 0}};
	int              hb [9] = '{0, 0, HB_2400, 0, 0, HB_1600, HB_3200, 0, 0};

	exciter_keying_channel_access #(.CHANNELS(4), .TICK_CYC(T),
		.MINUTE_TK(5)) exciter_keying_channel_access_inst (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
		.pages_waiting_i(waiting), .send_req_i(req), .send_channel_i(sch),
		.low_rate_pocsag_i(lowr), .last_bit_i(lastb), .page_data_i(pdata),
		.busy_pin_i(pin), .net_abort_i(nab), .net_abort_channel_i(nch),
		.frame_number_i(fnum), .frame_wr_i(fwr), .frame_wr_addr_i(faddr),
		.frame_wr_sel_i(fsel), .test_waveform_mode_i(tmode),
		.ident_done_i(idone), .keyline_o(key), .channel_select_o(csel),
		.data_o(dat), .send_grant_o(grant), .preamble_enable_a_active_o(warm),
		.ident_active_o(idact), .abort_o(abort_o),
		.busy_abort_notice_o(notice), .busy_abort_channel_o(bch),
		.channel_busy_o(cbusy));

	exciter_model exciter_model_inst (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .keyline_i(key), .carrier_i(carrier),
		.invert_i(cfg.busy_polarity_invert), .busy_pin_o(pin),
		.keyups_o(keyups));

	// ----------------------------------------
	// clock, timeout, notice capture
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (notice === 1'b1)
			nseen <= {1'b1, bch};
		if (cyc == 90000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk
	task automatic chk_in(input string s, input int lo, input int hi,
		input int g);
		checks_done++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("unexpected %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask : chk_in
	task automatic clk_n(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask : clk_n
	function automatic logic sig(input int k);
		case (k)
			0: return key;
			1: return grant;
			2: return idact;
			default: return |abort_o;
		endcase
	endfunction : sig
	task automatic wait_sig(input int k, input logic lv, input int mx,
		output int c);
		c = 0;
		while (sig(k) !== lv && c < mx) begin
			@(negedge core_clk_i);
			wseen |= (warm === 1'b1);
			c++;
		end
	endtask : wait_sig
	task automatic run_same(input int mx, output int c);
		c = 0;
		v = dat;
		while (dat === v && c < mx) begin
			@(negedge core_clk_i);
			c++;
		end
	endtask : run_same
	task automatic xfer(input logic [CH_W-1:0] ch, input int lead,
		input int tail, input logic id);
		int d;
		d = (ch != prev) ? 3 : 0;
		prev = ch;
		sch = ch;
		wseen = 1'b0;
		req = 1'b1;
		wait_sig(0, 1'b1, 5000, n);
		chk_in("key delay", (d - 1) * T, (d + 1) * T + 5, n);
		wait_sig(1, 1'b1, 5000, n);
		chk_in("lead", (lead - 1) * T, (lead + 1) * T + 5, n);
		chk("preamble_enable_a", 16'(lowr & cfg.preamble_enable_a), 16'(wseen));
		chk("select", cfg.select_as_keyline ? 16'h3 : 16'(ch), 16'(csel));
		pdata = 1'b1;
		clk_n(2);
		chk("data", 16'h1, 16'(dat));
		pdata = 1'b0;
		clk_n(2);
		chk("data", 16'h0, 16'(dat));
		lastb = 1'b1;
		clk_n(1);
		lastb = 1'b0;
		req = 1'b0;
		if (id) begin
			wait_sig(2, 1'b1, 60 * T, n);
			chk("ident", 16'h1, 16'(idact));
			idone = 1'b1;
			clk_n(1);
			idone = 1'b0;
			wait_sig(0, 1'b0, 5000, n);
		end else begin
			wait_sig(0, 1'b0, 5000, n);
			chk_in("tail", (tail - 1) * T, (tail + 1) * T + 5, n);
		end
		clk_n(3);
	endtask : xfer

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cfg = '0;
		{req, lastb, pdata, nab, fwr, fsel, lowr, idone, carrier} = '0;
		{waiting, tmode, sch, nch, prev, fnum, faddr, nseen} = '0;
		wseen = 1'b0;
		rstn_i = 1'b0;
		clk_n(8);
		chk("reset outs", 16'h0, 16'({key, grant, dat, notice, abort_o, csel}));
		rstn_i = 1'b1;
		clk_n(2);
		chk("after reset", 16'h0, 16'({key, grant, dat, notice, abort_o, csel}));
		foreach (brow[i]) begin
			cfg.busy_polarity_invert = brow[i][2];
			carrier = brow[i][1];
			clk_n(4);
			chk("busy", 16'(brow[i][0]), 16'(cbusy));
		end
		carrier = 1'b0;
		cfg.channel_change_delay = 8'h03;
		cfg.share_release_margin = 8'h02;
		foreach (xr[i]) begin
			cfg.keyup_lead_delay = 8'(xr[i][1]);
			cfg.keyup_tail_delay = 8'(xr[i][2]);
			cfg.channel_shared = xr[i][3][0];
			cfg.preamble_enable_a = xr[i][4][0];
			lowr = xr[i][4][0];
			cfg.select_as_keyline = xr[i][5][0];
			xfer(CH_W'(xr[i][0]), xr[i][1] + 10 * xr[i][4],
				xr[i][2] + 2 * xr[i][3], 1'b0);
		end
		// busy channel with pages queued, simulcast master
		cfg.master_mode = 1'b1;
		cfg.busy_abort_limit = 8'h03;
		waiting = 4'h8;
		carrier = 1'b1;
		sch = 2'h3;
		prev = 2'h3;
		req = 1'b1;
		wait_sig(3, 1'b1, 200, n);
		chk_in("busy abort time", 4 * T, 7 * T + 5, n);
		chk("abort", 16'h8, 16'(abort_o));
		chk("grant", 16'h0, 16'(grant));
		clk_n(3);
		chk("notice", 16'h7, 16'(nseen));
		{req, carrier} = '0;
		waiting = 4'h0;
		cfg.net_mode = 1'b1;
		nch = 2'h1;
		clk_n(3);
		nab = 1'b1;
		wait_sig(3, 1'b1, 8, n);
		chk("net abort", 16'h2, 16'(abort_o));
		nab = 1'b0;
		cfg.station_ident = 1'b1;
		lowr = 1'b0;
		xfer(2'h3, 1, 2, 1'b1);
		cfg.station_ident = 1'b0;
		cfg.sync_simulcast_mode = 1'b1;
		faddr = 7'h09;
		fsel = 1'b1;
		fwr = 1'b1;
		clk_n(1);
		fwr = 1'b0;
		fnum = 7'h08;
		req = 1'b1;
		wait_sig(1, 1'b1, 40 * T, n);
		chk("frame gate", 16'h0, 16'(grant));
		fnum = 7'h09;
		wait_sig(1, 1'b1, 40 * T, n);
		chk("frame gate", 16'h1, 16'(grant));
		lastb = 1'b1;
		clk_n(1);
		lastb = 1'b0;
		req = 1'b0;
		wait_sig(0, 1'b0, 5000, n);
		cfg.sync_simulcast_mode = 1'b0;
		chk("keyups", 16'h5, 16'(keyups));
		// periodic ident: 3 minutes of 5 ticks each
		cfg.ident_minutes = 6'd3;
		cfg.sync_simulcast_mode = 1'b1;
		wait_sig(2, 1'b1, 400, n);
		idone = 1'b1;
		clk_n(1);
		idone = 1'b0;
		wait_sig(2, 1'b1, 400, n);
		chk_in("ident period", 15 * T - 2, 15 * T + 2, n);
		idone = 1'b1;
		clk_n(1);
		idone = 1'b0;
		cfg.ident_minutes = 6'd7;
		wait_sig(2, 1'b1, 400, n);
		chk("ident n", 16'h0, 16'(idact));
		cfg.sync_simulcast_mode = 1'b0;
		foreach (hb[i]) begin
			tmode = 4'(i + 1);
			clk_n(20);
			if (hb[i] != 0) begin
				run_same(hb[i] + 10, n);
				run_same(hb[i] + 10, n);
				chk_in("half period", hb[i] - 1, hb[i] + 1, n);
			end
		end
		tmode = TW_STOP;
		clk_n(3);
		run_same(2000, n);
		chk_in("stopped", 2000, 2000, n);
		tally_and_finish();
	end
endmodule : exciter_keying_channel_access_tb

// ---- tb/exciter_model.sv ----
// Purpose: exciter stand-in that drives the carrier busy pin
// Assumes: carrier state is commanded by the bench
// Notes:   counts key-ups so the bench can cross-check keying
`timescale 1ns/1ps
module exciter_model (
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       keyline_i,
	input  wire logic       carrier_i,
	input  wire logic       invert_i,
	output logic            busy_pin_o,
	output logic [7:0]      keyups_o
);
	logic key_reg;

	// ----------------------------------------
	// busy pin, active low unless inverted
	// ----------------------------------------
	assign busy_pin_o = invert_i ? carrier_i : ~carrier_i;

	// ----------------------------------------
	// key-up counter
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			key_reg  <= 1'b0;
			keyups_o <= 8'h00;
		end else begin
			key_reg <= keyline_i;
			if (keyline_i && !key_reg)
				keyups_o <= keyups_o + 8'h01;
		end
	end
endmodule : exciter_model
